// ---- logic/sioej_pkg.sv ----
// Constants, state encoding and state record of the stage I/O controller.
package sioej_pkg;
  // Clock and time base.
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;
  localparam logic [27:0] STEP_WRAP = 28'(CLK_HZ);
  // Speed settings, held in units of 100 pulses per second, and the ramp time limit in ms.
  localparam logic [7:0] PPS_UNIT = 8'h64;
  localparam logic [7:0] SPD_LO_U = 8'h01;
  localparam logic [7:0] SPD_HI_U = 8'hc8;
  localparam logic [9:0] ACC_HI_MS = 10'h3e8;
  // Host link baud rates and bit periods in cycles.
  localparam int unsigned BAUD0 = 4800;
  localparam int unsigned BAUD1 = 9600;
  localparam int unsigned BAUD2 = 19200;
  localparam int unsigned BAUD3 = 38400;
  localparam logic [15:0] DIV0 = 16'(CLK_HZ / BAUD0);
  localparam logic [15:0] DIV1 = 16'(CLK_HZ / BAUD1);
  localparam logic [15:0] DIV2 = 16'(CLK_HZ / BAUD2);
  localparam logic [15:0] DIV3 = 16'(CLK_HZ / BAUD3);
  // Register byte offsets.
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_GOUT = 8'h04;
  localparam logic [7:0] OFS_GIN = 8'h08;
  localparam logic [7:0] OFS_MAXSPD = 8'h0c;
  localparam logic [7:0] OFS_MINSPD = 8'h10;
  localparam logic [7:0] OFS_ACCEL = 8'h14;
  localparam logic [7:0] OFS_CMD = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_POS = 8'h20;
  localparam logic [7:0] OFS_IRQST = 8'h24;
  localparam logic [7:0] OFS_IRQCLR = 8'h28;
  localparam logic [7:0] OFS_IRQEN = 8'h2c;
  // Configuration field positions.
  localparam int CFG_FULL = 0;
  localparam int CFG_CENTER = 1;
  localparam int CFG_LSNO = 2;
  localparam int CFG_ESDEEN = 3;
  localparam int CFG_FLOW = 4;
  localparam int CFG_BAUD = 5;
  localparam int CFG_HOLD = 7;
  // Command field positions.
  localparam int CMD_POS = 0;
  localparam int CMD_NEG = 1;
  localparam int CMD_STOP = 2;
  localparam int CMD_HOME = 3;
  localparam int CMD_HALT = 4;
  // Interrupt event positions.
  localparam int EV_ESTOP = 0;
  localparam int EV_LIMIT = 1;
  localparam int EV_DONE = 2;
  localparam int EV_GIN = 3;
  localparam int EV_ESREL = 4;
  // Reset values.
  localparam logic [7:0] CFG_RST = 8'ha0;
  localparam logic [7:0] MINSPD_RST = 8'h05;
  localparam logic [7:0] MAXSPD_RST = 8'h32;
  localparam logic [9:0] ACCEL_RST = 10'h0c8;
  localparam logic [2:0] PH_RST = 3'h0;
  // Motion states.
  typedef enum logic [4:0] {
    SIOEJ_IDLE = 5'b00001,
    SIOEJ_RUN = 5'b00010,
    SIOEJ_SEEKNEG = 5'b00100,
    SIOEJ_SEEKPOS = 5'b01000,
    SIOEJ_TOMID = 5'b10000
  } sioej_state_t;
  // Whole state of the controller.
  typedef struct packed {
    logic [10:0] sync1;
    logic [10:0] sync2;
    logic [3:0] genOut;
    logic [7:0] cfg;
    logic [7:0] minU;
    logic [7:0] maxU;
    logic [9:0] accMs;
    logic [4:0] irqSt;
    logic [4:0] irqEn;
    logic [31:0] prdata;
    logic pslverr;
    sioej_state_t st;
    logic dir;
    logic slow;
    logic jog;
    logic [27:0] acc;
    logic [27:0] rampAcc;
    logic [7:0] curU;
    logic [31:0] pos;
    logic [31:0] tgt;
    logic [2:0] ph;
    logic [3:0] wind;
    logic esPrev;
    logic [3:0] giPrev;
    logic [15:0] linkDiv;
    logic rts;
  } sioej_regs_t;
endpackage

// ---- logic/sioej_stage_io.sv ----
// Stage I/O, emergency stop, jog and motion control with an APB slave.
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/10ps
module sioej_stage_io (
  input wire logic clock,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] generalInputs,
  output logic [3:0] generalOutputs,
  input wire logic estopInput,
  input wire logic estopEnableJumper,
  input wire logic jogPosInput,
  input wire logic jogNegInput,
  input wire logic limitPosInput,
  input wire logic limitNegInput,
  input wire logic linkCtsInput,
  output logic linkRtsOutput,
  output logic linkTxPermit,
  output logic [15:0] linkBitCycles,
  output logic [3:0] windingDrive,
  output logic irq
);
  import sioej_pkg::*;

  sioej_regs_t r;
  sioej_regs_t next_r;

  // Synchronised pins, named for readability.
  logic [3:0] gin;
  logic esIn;
  logic esJmp;
  logic jogP;
  logic jogN;
  logic limP;
  logic limN;
  logic cts;
  assign gin = r.sync2[3:0];
  assign esIn = r.sync2[4];
  assign esJmp = r.sync2[5];
  assign jogP = r.sync2[6];
  assign jogN = r.sync2[7];
  assign limP = r.sync2[8];
  assign limN = r.sync2[9];
  assign cts = r.sync2[10];

  // Half-step pattern; odd entries energise two phases at once.
  function automatic logic [3:0] phasePattern(input logic [2:0] idx);
    case (idx)
      3'h0: phasePattern = 4'h1;
      3'h1: phasePattern = 4'h3;
      3'h2: phasePattern = 4'h2;
      3'h3: phasePattern = 4'h6;
      3'h4: phasePattern = 4'h4;
      3'h5: phasePattern = 4'hc;
      3'h6: phasePattern = 4'h8;
      default: phasePattern = 4'h9;
    endcase
  endfunction

  // Derived conditions used by the motion logic and the bus.
  logic esActive;
  logic limPAct;
  logic limNAct;
  logic jogPReq;
  logic jogNReq;
  logic idle;
  logic [7:0] topU;
  logic [7:0] wantU;
  logic [14:0] curPps;
  logic [27:0] rampLen;
  logic [27:0] accSum;
  logic [27:0] rampSum;
  logic stepNow;
  logic rampTick;
  logic limHit;
  assign esActive = esJmp & ~esIn;
  // A normally closed sensor opens, reading low, at the limit.
  assign limPAct = r.cfg[CFG_LSNO] ? limP : ~limP;
  assign limNAct = r.cfg[CFG_LSNO] ? limN : ~limN;
  // Opposing jog requests cancel each other.
  assign jogPReq = jogP & ~jogN & ~esActive;
  assign jogNReq = jogN & ~jogP & ~esActive;
  assign idle = (r.st == SIOEJ_IDLE);
  assign topU = (r.maxU > r.minU) ? r.maxU : r.minU;
  assign wantU = r.slow ? r.minU : topU;
  assign curPps = 15'(r.curU * PPS_UNIT);
  assign rampLen = 28'(r.accMs * CYC_PER_MS);
  assign accSum = r.acc + 28'(curPps);
  assign rampSum = r.rampAcc + 28'(topU - r.minU);
  assign stepNow = ~idle & (accSum >= STEP_WRAP);
  assign rampTick = (rampLen == 28'h0) | (rampSum >= rampLen);
  assign limHit = r.dir ? limPAct : limNAct;

  // Bus decode for the setup and access cycles.
  logic setup;
  logic access;
  logic wrAcc;
  logic [31:0] rdMux;
  logic errMux;
  logic [7:0] wU;
  logic startCmd;
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign wrAcc = access & pwrite;
  assign wU = pwdata[7:0];
  assign startCmd = |pwdata[CMD_HOME:CMD_POS] & ~pwdata[CMD_STOP];

  // Read data and error, both settled before the access cycle.
  always_comb begin
    rdMux = 32'h0;
    errMux = 1'b0;
    case (paddr)
      OFS_CFG: rdMux = {24'h0, r.cfg};
      OFS_GOUT: rdMux = {28'h0, r.genOut};
      OFS_GIN: rdMux = {28'h0, gin};
      OFS_MAXSPD: begin
        rdMux = {24'h0, r.maxU};
        errMux = pwrite & ((wU < SPD_LO_U) | (wU > SPD_HI_U));
      end
      OFS_MINSPD: begin
        rdMux = {24'h0, r.minU};
        errMux = pwrite & ((wU < SPD_LO_U) | (wU > SPD_HI_U));
      end
      OFS_ACCEL: begin
        rdMux = {22'h0, r.accMs};
        errMux = pwrite & (pwdata[9:0] > ACC_HI_MS);
      end
      // A start is refused while moving or during the stop condition.
      OFS_CMD: errMux = pwrite & startCmd & (~idle | esActive);
      OFS_STATUS: rdMux = {20'h0, limNAct, limPAct, jogN, jogP,
                           esActive, r.dir, r.st, idle};
      OFS_POS: rdMux = r.pos;
      OFS_IRQST: rdMux = {27'h0, r.irqSt};
      OFS_IRQCLR: rdMux = 32'h0;
      OFS_IRQEN: rdMux = {27'h0, r.irqEn};
      default: errMux = 1'b1;
    endcase
  end

  // Next state of the whole controller.
  always_comb begin
    next_r = r;
    next_r.sync1 = {linkCtsInput, limitNegInput, limitPosInput,
                    jogNegInput, jogPosInput, estopEnableJumper,
                    estopInput, generalInputs};
    next_r.sync2 = r.sync1;
    next_r.esPrev = esActive;
    next_r.giPrev = gin;
    if (setup) begin
      next_r.prdata = rdMux;
      next_r.pslverr = errMux;
    end

    // Step timing and ramping between start and top speed.
    if (idle) begin
      next_r.acc = 28'h0;
      next_r.rampAcc = 28'h0;
      next_r.curU = r.minU;
    end else begin
      next_r.acc = stepNow ? accSum - STEP_WRAP : accSum;
      if (rampLen == 28'h0) begin
        next_r.curU = wantU;
      end else if (rampTick) begin
        next_r.rampAcc = rampSum - rampLen;
        if (r.curU < wantU) begin
          next_r.curU = r.curU + 8'h01;
        end else if (r.curU > wantU) begin
          next_r.curU = r.curU - 8'h01;
        end
      end else begin
        next_r.rampAcc = rampSum;
      end
    end

    // Position and phase advance; full step moves two half steps.
    if (stepNow) begin
      next_r.pos = r.dir ? r.pos + 32'h1 : r.pos - 32'h1;
      if (r.cfg[CFG_FULL]) begin
        next_r.ph = r.dir ? r.ph + 3'h2 : r.ph - 3'h2;
      end else begin
        next_r.ph = r.dir ? r.ph + 3'h1 : r.ph - 3'h1;
      end
    end

    // Motion sequencing.
    case (r.st)
      SIOEJ_IDLE: begin
        next_r.slow = 1'b0;
        next_r.jog = 1'b0;
        if (jogPReq | jogNReq) begin
          next_r.st = SIOEJ_RUN;
          next_r.dir = jogPReq;
          next_r.jog = 1'b1;
        end
      end
      SIOEJ_RUN: begin
        if (r.jog & ~(r.dir ? jogPReq : jogNReq)) begin
          next_r.slow = 1'b1;
        end
        if (r.slow & (r.curU <= r.minU)) begin
          next_r.st = SIOEJ_IDLE;
        end
      end
      SIOEJ_SEEKNEG: begin
        if (limNAct) begin
          next_r.pos = 32'h0;
          next_r.dir = 1'b1;
          next_r.st = r.cfg[CFG_CENTER] ? SIOEJ_SEEKPOS : SIOEJ_IDLE;
        end
      end
      SIOEJ_SEEKPOS: begin
        if (limPAct) begin
          next_r.tgt = {1'b0, r.pos[31:1]};
          next_r.dir = 1'b0;
          next_r.st = SIOEJ_TOMID;
        end
      end
      SIOEJ_TOMID: begin
        if (r.pos == r.tgt) begin
          next_r.pos = 32'h0;
          next_r.st = SIOEJ_IDLE;
        end
      end
      default: next_r.st = SIOEJ_IDLE;
    endcase

    // Limits in the travel direction stop a plain move at once.
    if ((r.st == SIOEJ_RUN) & limHit) begin
      next_r.st = SIOEJ_IDLE;
    end

    // Register writes, taken in the access cycle.
    if (wrAcc & ~r.pslverr) begin
      case (paddr)
        OFS_CFG: next_r.cfg = wU;
        OFS_GOUT: next_r.genOut = pwdata[3:0];
        OFS_MAXSPD: next_r.maxU = wU;
        OFS_MINSPD: next_r.minU = wU;
        OFS_ACCEL: next_r.accMs = pwdata[9:0];
        OFS_CMD: begin
          if (pwdata[CMD_HALT]) begin
            next_r.st = SIOEJ_IDLE;
          end else if (pwdata[CMD_STOP]) begin
            next_r.slow = 1'b1;
          end else if (idle & pwdata[CMD_HOME]) begin
            next_r.st = SIOEJ_SEEKNEG;
            next_r.dir = 1'b0;
            next_r.slow = 1'b1;
          end else if (idle & (pwdata[CMD_POS] ^ pwdata[CMD_NEG])) begin
            next_r.st = SIOEJ_RUN;
            next_r.dir = pwdata[CMD_POS];
            next_r.jog = 1'b0;
          end
        end
        OFS_IRQEN: next_r.irqEn = pwdata[4:0];
        default: next_r.cfg = r.cfg;
      endcase
    end

    // Stop condition overrides every start and any motion.
    if (esActive) begin
      next_r.st = SIOEJ_IDLE;
    end

    // Windings: free on request, or during stop if so configured.
    if (~r.cfg[CFG_HOLD] | (esActive & r.cfg[CFG_ESDEEN])) begin
      next_r.wind = 4'h0;
    end else begin
      next_r.wind = phasePattern(next_r.ph);
    end

    // Host link timing and flow control.
    case (r.cfg[CFG_BAUD+1:CFG_BAUD])
      2'h0: next_r.linkDiv = DIV0;
      2'h1: next_r.linkDiv = DIV1;
      2'h2: next_r.linkDiv = DIV2;
      default: next_r.linkDiv = DIV3;
    endcase
    next_r.rts = 1'b1;

    // Sticky events; a clear never hides an event of the same cycle.
    if (wrAcc & (paddr == OFS_IRQCLR)) begin
      next_r.irqSt = r.irqSt & ~pwdata[4:0];
    end else begin
      next_r.irqSt = r.irqSt;
    end
    next_r.irqSt[EV_ESTOP] = next_r.irqSt[EV_ESTOP] | (esActive & ~r.esPrev);
    next_r.irqSt[EV_ESREL] = next_r.irqSt[EV_ESREL] | (~esActive & r.esPrev);
    next_r.irqSt[EV_LIMIT] = next_r.irqSt[EV_LIMIT]
                             | ((r.st == SIOEJ_RUN) & limHit);
    next_r.irqSt[EV_DONE] = next_r.irqSt[EV_DONE]
                            | (~idle & (next_r.st == SIOEJ_IDLE));
    next_r.irqSt[EV_GIN] = next_r.irqSt[EV_GIN] | (gin != r.giPrev);
  end

  // Single state register; synchronous active-low reset.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      r <= '0;
      r.cfg <= CFG_RST;
      r.minU <= MINSPD_RST;
      r.maxU <= MAXSPD_RST;
      r.accMs <= ACCEL_RST;
      r.st <= SIOEJ_IDLE;
      r.ph <= PH_RST;
      r.linkDiv <= DIV1;
    end else begin
      r <= next_r;
    end
  end

  // Outputs. Zero-wait slave: data is prepared during setup.
  assign prdata = r.prdata;
  assign pready = 1'b1;
  assign pslverr = access & r.pslverr;
  assign generalOutputs = r.genOut;
  assign windingDrive = r.wind;
  assign linkRtsOutput = r.rts & r.cfg[CFG_FLOW];
  // Without flow control the transmitter never waits for clear-to-send.
  assign linkTxPermit = ~r.cfg[CFG_FLOW] | cts;
  assign linkBitCycles = r.linkDiv;
  assign irq = |(r.irqSt & r.irqEn);
endmodule

// ---- test/sioej_stage_io_assertions.sv ----
// Port checker for the stage I/O controller, bound to its top module.
`timescale 1ns/10ps
module sioej_stage_io_checker
  import sioej_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic [3:0] generalInputs,
  input wire logic [3:0] generalOutputs,
  input wire logic estopInput,
  input wire logic estopEnableJumper,
  input wire logic [3:0] windingDrive
);
  logic [2:0] giCnt;
  logic [3:0] giLast;
  logic [3:0] esCnt;
  logic wrAcc;
  assign wrAcc = psel && penable && pwrite;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  // Quiet-pin counters; pins pass two flops, so a count of three means
  // the synchronised copy has caught up with the pin.
  always_ff @(posedge clock) begin
    giLast <= generalInputs;
    if (!resetn || giLast != generalInputs) begin
      giCnt <= 3'h0;
    end else if (giCnt != 3'h7) begin
      giCnt <= giCnt + 3'h1;
    end
    if (!resetn || !estopEnableJumper || estopInput) begin
      esCnt <= 4'h0;
    end else if (esCnt != 4'hf) begin
      esCnt <= esCnt + 4'h1;
    end
  end
  gout_write_a: assert property (
    wrAcc && paddr == OFS_GOUT |=>
    {28'h0, generalOutputs} == ($past(pwdata) & 32'hf))
    else $error("output pins differ from written value");
  gout_hold_a: assert property (
    !(wrAcc && paddr == OFS_GOUT) |=> $stable(generalOutputs))
    else $error("output pins changed without a write");
  gin_read_a: assert property (
    psel && !penable && !pwrite && paddr == OFS_GIN && giCnt >= 3'h3 &&
    $stable(generalInputs) |=> prdata == {28'h0, $past(generalInputs)})
    else $error("input read does not match pins");
  maxspd_range_a: assert property (
    wrAcc && paddr == OFS_MAXSPD |-> pslverr == (pwdata - 32'h1 > 32'hc7))
    else $error("top speed range check wrong");
  minspd_range_a: assert property (
    wrAcc && paddr == OFS_MINSPD |-> pslverr == (pwdata - 32'h1 > 32'hc7))
    else $error("start speed range check wrong");
  accel_range_a: assert property (
    wrAcc && paddr == OFS_ACCEL |-> pslverr == (pwdata > 32'h3e8))
    else $error("ramp time range check wrong");
  start_refused_a: assert property (
    wrAcc && paddr == OFS_CMD && pwdata[4:0] == 5'h01 && esCnt >= 4'h3
    |-> pslverr)
    else $error("start accepted during stop");
  estop_frozen_a: assert property (
    esCnt >= 4'h6 |-> $stable(windingDrive))
    else $error("windings moved during stop");
endmodule
bind sioej_stage_io sioej_stage_io_checker sioej_stage_io_checker_i (
  .clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pslverr(pslverr), .generalInputs(generalInputs),
  .generalOutputs(generalOutputs), .estopInput(estopInput),
  .estopEnableJumper(estopEnableJumper), .windingDrive(windingDrive)
);

// ---- test/sioej_pin_partner.sv ----
// Model of the external controlling device on the isolated pins.
`timescale 1ns/10ps
module sioej_pin_partner (
  input wire logic clock,
  input wire logic [3:0] wantGin,
  input wire logic wantStop,
  input wire logic wantJogPos,
  input wire logic wantJogNeg,
  input wire logic [3:0] generalOutputs,
  output logic [3:0] generalInputs = 4'h0,
  output logic estopInput = 1'b1,
  output logic jogPosInput = 1'b0,
  output logic jogNegInput = 1'b0,
  output logic [3:0] seenOutputs = 4'h0
);
  // Contacts follow the wishes one edge later, never mid-cycle.
  always_ff @(posedge clock) begin
    generalInputs <= wantGin;
    estopInput <= !wantStop;
    jogPosInput <= wantJogPos;
    jogNegInput <= wantJogNeg;
    seenOutputs <= generalOutputs;
  end
endmodule

// ---- test/stage_io_estop_jog_control_tb_top.sv ----
// Self-checking bench of the stage I/O controller.
`timescale 1ns/10ps
module stage_io_estop_jog_control_tb_top;
  import sioej_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic jumper = 1'b0;
  logic [3:0] wantGin = 4'h0;
  logic wantStop = 1'b0;
  logic jogP = 1'b0;
  logic jogN = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, irq, estop, jogPos, jogNeg;
  logic [3:0] gin, gout, seenOut, windingDrive;
  logic cts = 1'b1;
  logic rts, txOk;
  logic [15:0] bitCyc;
  int nErrors = 0;
  int checksDone = 0;
  // Free-running 250 MHz clock.
  always #2 clock = ~clock;
  sioej_stage_io sioej_stage_io_i (
    .clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .generalInputs(gin),
    .generalOutputs(gout), .estopInput(estop),
    .estopEnableJumper(jumper), .jogPosInput(jogPos),
    .jogNegInput(jogNeg), .limitPosInput(1'b1), .limitNegInput(1'b1),
    .linkCtsInput(cts), .linkRtsOutput(rts), .linkTxPermit(txOk),
    .linkBitCycles(bitCyc), .windingDrive(windingDrive), .irq(irq)
  );
  sioej_pin_partner sioej_pin_partner_i (
    .clock(clock), .wantGin(wantGin), .wantStop(wantStop),
    .wantJogPos(jogP), .wantJogNeg(jogN), .generalOutputs(gout),
    .generalInputs(gin), .estopInput(estop), .jogPosInput(jogPos),
    .jogNegInput(jogNeg), .seenOutputs(seenOut)
  );
  task automatic testDone();
    $display("checks %0d errors %0d", checksDone, nErrors);
    if (nErrors == 0 && checksDone > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checksDone++;
    if (seen !== want) begin
      nErrors++;
      $display("wrong value at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // One transfer; an idle edge at the end keeps back-to-back calls from
  // driving psel twice in one time step.
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      nErrors++;
      testDone();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic e);
    logic [31:0] r;
    logic er;
    apb(1'b1, a, d, r, er);
    check({31'h0, er}, {31'h0, e});
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic er;
    apb(1'b0, a, 32'h0, r, er);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] want);
    logic [31:0] r;
    rd(a, r);
    check(r, want);
  endtask
  // Polls the position; the bound covers one step at 20000 pps.
  // A wait that must see a step and runs out ends the run as a failure.
  task automatic waitPos(input logic [31:0] old, input logic mustMove,
      output logic [31:0] p);
    p = old;
    for (int i = 0; i < 5000 && p === old; i++) begin
      rd(OFS_POS, p);
    end
    if (mustMove && p === old) begin
      nErrors++;
      testDone();
    end
  endtask
  // Bit period per baud select, and clear-to-send gating with flow on.
  task automatic tLink();
    int unsigned b;
    for (int i = 0; i < 4; i++) begin
      case (i)
        0: b = BAUD0;
        1: b = BAUD1;
        2: b = BAUD2;
        default: b = BAUD3;
      endcase
      wr(OFS_CFG, 32'h90 | (32'(i) << 5), 1'b0);
      tick(1);
      check({16'h0, bitCyc}, 32'(CLK_HZ / b));
    end
    cts <= 1'b0;
    tick(5);
    check({31'h0, txOk}, 32'h0);
    check({31'h0, rts}, 32'h1);
    cts <= 1'b1;
    tick(5);
    check({31'h0, txOk}, 32'h1);
    wr(OFS_CFG, 32'h80, 1'b0);
    cts <= 1'b0;
    tick(5);
    check({31'h0, txOk}, 32'h1);
    check({31'h0, rts}, 32'h0);
    cts <= 1'b1;
    wr(OFS_CFG, {24'h0, CFG_RST}, 1'b0);
  endtask
  task automatic tReset();
    rdc(OFS_CFG, {24'h0, CFG_RST});
    rdc(OFS_MINSPD, {24'h0, MINSPD_RST});
    rdc(OFS_MAXSPD, {24'h0, MAXSPD_RST});
    rdc(OFS_ACCEL, {22'h0, ACCEL_RST});
    check({28'h0, gout}, 32'h0);
  endtask
  task automatic tOutputs();
    for (int i = 0; i < 16; i++) begin
      wr(OFS_GOUT, 32'(i), 1'b0);
      check({28'h0, gout}, 32'(i));
      rdc(OFS_GOUT, 32'(i));
    end
    check({28'h0, seenOut}, 32'hf);
  endtask
  // Each input change raises the input event; it is cleared, then masked.
  task automatic tInputs();
    wr(OFS_IRQEN, 32'h8, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wantGin <= 4'h1 << i;
      tick(5);
      rdc(OFS_GIN, 32'h1 << i);
      check({31'h0, irq}, 32'h1);
      wr(OFS_IRQCLR, 32'h8, 1'b0);
      check({31'h0, irq}, 32'h0);
    end
    wr(OFS_IRQEN, 32'h0, 1'b0);
    wantGin <= 4'h0;
    tick(5);
    check({31'h0, irq}, 32'h0);
    rdc(OFS_IRQST, 32'h8);
    wr(OFS_IRQCLR, 32'h1f, 1'b0);
  endtask
  // Range edges; each speed reads back the last value written to it that was accepted.
  task automatic tRanges();
    wr(OFS_MAXSPD, 32'h0, 1'b1);
    wr(OFS_MAXSPD, 32'h1, 1'b0);
    wr(OFS_MAXSPD, 32'hc9, 1'b1);
    wr(OFS_MAXSPD, 32'hc8, 1'b0);
    wr(OFS_MINSPD, 32'h0, 1'b1);
    wr(OFS_MINSPD, 32'hc9, 1'b1);
    wr(OFS_MINSPD, 32'hc8, 1'b0);
    wr(OFS_ACCEL, 32'h3e9, 1'b1);
    wr(OFS_ACCEL, 32'h3e8, 1'b0);
    wr(OFS_ACCEL, 32'h0, 1'b0);
    wr(8'h30, 32'h0, 1'b1);
    rdc(OFS_MAXSPD, 32'hc8);
    rdc(OFS_MINSPD, 32'hc8);
  endtask
  task automatic tEstop();
    logic [31:0] r;
    wantStop <= 1'b1;
    tick(5);
    wr(OFS_CMD, 32'h1, 1'b0);
    rd(OFS_STATUS, r);
    check({27'h0, r[5:1]}, 32'h2);
    wr(OFS_CFG, {24'h0, CFG_RST | 8'h08}, 1'b0);
    jumper <= 1'b1;
    tick(6);
    rd(OFS_STATUS, r);
    check({25'h0, r[7:6] & 2'h2, r[5:1]}, 32'h41);
    check({28'h0, windingDrive}, 32'h0);
    wr(OFS_CMD, 32'h1, 1'b1);
    wr(OFS_CMD, 32'h8, 1'b1);
    jogP <= 1'b1;
    tick(6);
    rd(OFS_STATUS, r);
    check({27'h0, r[5:1]}, 32'h1);
    jogP <= 1'b0;
    wantStop <= 1'b0;
    tick(5);
    rd(OFS_STATUS, r);
    check({31'h0, r[7]}, 32'h0);
    rdc(OFS_IRQST, 32'h15);
    wr(OFS_IRQCLR, 32'h1f, 1'b0);
    wr(OFS_CFG, {24'h0, CFG_RST}, 1'b0);
  endtask
  task automatic tJog();
    logic [31:0] p0, p1, p2;
    rd(OFS_POS, p0);
    jogP <= 1'b1;
    waitPos(p0, 1'b1, p1);
    check({31'h0, $signed(p1) > $signed(p0)}, 32'h1);
    jogP <= 1'b0;
    tick(10);
    jogN <= 1'b1;
    waitPos(p1, 1'b1, p2);
    check({31'h0, $signed(p2) < $signed(p1)}, 32'h1);
    jogP <= 1'b1;
    tick(10);
    rd(OFS_POS, p0);
    waitPos(p0, 1'b0, p1);
    check(p1, p0);
    jogP <= 1'b0;
    jogN <= 1'b0;
  endtask
  // Reset for 20 cycles, then the scenarios in turn.
  initial begin
    tick(20);
    resetn <= 1'b1;
    tick(2);
    tReset();
    tOutputs();
    tInputs();
    tRanges();
    tLink();
    tEstop();
    tJog();
    testDone();
  end
endmodule
